// ==== verilog/port_iso_pkg.sv ====
/*
  Constants for the root-port status register and the isochronous descriptor maps:
  register offsets, field positions, reset values and the scheduler walk states.
  Assumes a 16-bit byte address on the processor side and 32 descriptors per category.
*/
package port_iso_pkg;
  localparam logic [15:0] PORTSC_OFF = 16'h0064;
  localparam logic [15:0] ISO_DONE_OFF = 16'h0130;
  localparam logic [15:0] ISO_BYPASS_OFF = 16'h0134;

  localparam int TEST_LSB = 16;
  localparam int TEST_MSB = 19;
  localparam int IND_LSB = 14;
  localparam int IND_MSB = 15;
  localparam int OWN_BIT = 13;
  localparam int POWER_BIT = 12;
  localparam int DP_BIT = 11;
  localparam int DM_BIT = 10;
  localparam int PRST_BIT = 8;
  localparam int SLEEP_BIT = 7;
  localparam int RESUME_BIT = 6;
  localparam int ENABLE_BIT = 2;
  localparam int CHANGE_BIT = 1;
  localparam int PRESENT_BIT = 0;

  localparam logic [3:0] TEST_RST = 4'h0;
  localparam logic [1:0] IND_RST = 2'h0;
  localparam logic OWN_RST = 1'b1;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [31:0] DONE_RST = 32'h00000000;
  localparam logic [31:0] BYPASS_RST = 32'hffffffff;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

  typedef enum logic {WALK_IDLE, WALK_RUN} walk_state_t;
endpackage

// ==== verilog/skip_scan_if.sv ====
/*
  Interface between the register bank and the descriptor skip decision.
  Assumes the bank drives the current position and the descriptor's fields.
*/
`timescale 1ns/10ps
interface skip_scan_if #(parameter int COUNT = 32, parameter int IW = 5);
  logic [IW-1:0] index;
  logic [COUNT-1:0] bypass;
  logic valid;
  logic link_valid;
  logic [IW-1:0] link;
  logic process;
  logic [IW-1:0] next_index;
  modport scan (input index, input bypass, input valid, input link_valid, input link,
                output process, output next_index);
  modport ctrl (output index, output bypass, output valid, output link_valid, output link,
                input process, input next_index);
endinterface

// ==== verilog/descriptor_skip_scan.sv ====
/*
  Combinational skip decision for one descriptor position of the isochronous category.
  Assumes COUNT is a power of two, so the step past the last position wraps to zero.
*/
`timescale 1ns/10ps
module descriptor_skip_scan #(
  parameter int COUNT = 32,
  parameter int IW = 5
) (
  skip_scan_if.scan scan
);
  wire logic bypassed;

  assign bypassed = scan.bypass[scan.index];
  // A bypassed slot is never processed, whatever its valid flag says.
  assign scan.process = scan.valid & ~bypassed;
  // The link of a skipped slot is ignored; the walk just moves on.
  assign scan.next_index = (scan.process & scan.link_valid) ? scan.link : IW'(scan.index + 1'b1);
endmodule // descriptor_skip_scan

// ==== verilog/port_status_iso_regs.sv ====
/*
  Root-port status and control register plus the isochronous completion and bypass maps,
  with the descriptor walk that honours the bypass map.
  Assumes a simple synchronous processor port (one-cycle read and write strobes), port
  status levels synchronous to clock, and completion pulses from the scheduler.
*/
`timescale 1ns/10ps

module port_status_iso_regs #(
  parameter int COUNT = 32,
  parameter int IW = 5
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  input wire logic configured_flag,
  input wire logic indicator_capable,
  input wire logic power_switch_capable,
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic port_connected,
  input wire logic port_in_reset,
  input wire logic port_suspended,
  input wire logic resume_detected,
  input wire logic [COUNT-1:0] desc_done,
  input wire logic sched_start,
  input wire logic sched_stop,
  input wire logic sched_step,
  input wire logic desc_valid,
  input wire logic desc_link_valid,
  input wire logic [IW-1:0] desc_link,
  output logic [3:0] port_test_select,
  output logic [1:0] indicator_control,
  output logic companion_ownership,
  output logic port_power,
  output logic port_enable,
  output logic sleep_request,
  output logic resume_drive,
  output logic sched_active,
  output logic [IW-1:0] sched_index,
  output logic sched_process
);
  logic [31:0] rdata_reg;
  logic [3:0] test_reg;
  logic [1:0] ind_reg;
  logic own_reg;
  logic power_reg;
  logic power_out_reg;
  logic enable_reg;
  logic sleep_reg;
  logic resume_reg;
  logic present_reg;
  logic change_reg;
  logic cf_prev_reg;
  logic [COUNT-1:0] done_reg;
  logic [COUNT-1:0] bypass_reg;
  port_iso_pkg::walk_state_t walk_reg;
  logic [IW-1:0] index_reg;
  logic process_reg;

  wire logic wr_portsc;
  wire logic wr_bypass;
  wire logic rd_done;
  wire logic eff_power;
  wire logic cf_rise;
  wire logic sleep_view;
  wire logic resume_view;
  wire logic own_next;
  wire logic [1:0] ind_next;
  wire logic enable_next;
  wire logic change_next;
  wire logic [COUNT-1:0] done_next;
  wire logic [31:0] portsc_view;
  wire logic [31:0] read_value;
  wire logic walk_advance;

  skip_scan_if #(.COUNT(COUNT), .IW(IW)) scan_bus ();

  descriptor_skip_scan #(.COUNT(COUNT), .IW(IW)) skip_scan (
    .scan(scan_bus.scan)
  );

  assign wr_portsc = bus_wr & (bus_addr == port_iso_pkg::PORTSC_OFF);
  assign wr_bypass = bus_wr & (bus_addr == port_iso_pkg::ISO_BYPASS_OFF);
  assign rd_done = bus_rd & (bus_addr == port_iso_pkg::ISO_DONE_OFF);

  // Without switching capability the port is powered for good and the bit is fixed at one.
  assign eff_power = power_switch_capable ? power_reg : 1'b1;
  assign cf_rise = configured_flag & ~cf_prev_reg;
  assign sleep_view = sleep_reg | port_suspended;
  assign resume_view = resume_reg | resume_detected;

  // Holding ownership while unconfigured takes priority over the rising-edge clear.
  assign own_next = !configured_flag ? 1'b1 :
                    cf_rise ? 1'b0 :
                    wr_portsc ? bus_wdata[port_iso_pkg::OWN_BIT] : own_reg;
  assign ind_next = (wr_portsc & indicator_capable) ?
                    bus_wdata[port_iso_pkg::IND_MSB:port_iso_pkg::IND_LSB] : ind_reg;
  // A detach disables the port, so a stale enable never outlives its device.
  assign enable_next = (present_reg & ~port_connected) ? 1'b0 :
                       wr_portsc ? bus_wdata[port_iso_pkg::ENABLE_BIT] : enable_reg;
  // Writing one acknowledges the change; a fresh change in the same cycle wins.
  assign change_next = (port_connected != present_reg) |
                       (change_reg & ~(wr_portsc & bus_wdata[port_iso_pkg::CHANGE_BIT]));
  // Clear-on-read drops only what was returned; new completions are ORed in last.
  assign done_next = (done_reg & ~(rd_done ? done_reg : {COUNT{1'b0}})) | desc_done;

  // Status and indicator fields are gated by port power; test, owner and line state are not.
  assign portsc_view = {12'h000, test_reg, ind_reg & {2{eff_power}}, own_reg, eff_power,
                        line_dp, line_dm, 1'b0,
                        port_in_reset & eff_power,
                        sleep_view & eff_power, resume_view & eff_power, 3'h0,
                        enable_reg & eff_power, change_reg & eff_power,
                        present_reg & eff_power};

  assign read_value = (bus_addr == port_iso_pkg::PORTSC_OFF) ? portsc_view :
                      (bus_addr == port_iso_pkg::ISO_DONE_OFF) ? 32'(done_reg) :
                      (bus_addr == port_iso_pkg::ISO_BYPASS_OFF) ? 32'(bypass_reg) : 32'h00000000;

  assign scan_bus.index = index_reg;
  assign scan_bus.bypass = bypass_reg;
  assign scan_bus.valid = desc_valid;
  assign scan_bus.link_valid = desc_link_valid;
  assign scan_bus.link = desc_link;
  assign walk_advance = (walk_reg == port_iso_pkg::WALK_RUN) & sched_step;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_reg <= port_iso_pkg::RDATA_RST;
    end else if (bus_rd) begin
      rdata_reg <= read_value;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      test_reg <= port_iso_pkg::TEST_RST;
      power_reg <= port_iso_pkg::FLAG_RST;
      sleep_reg <= port_iso_pkg::FLAG_RST;
      resume_reg <= port_iso_pkg::FLAG_RST;
    end else if (wr_portsc) begin
      test_reg <= bus_wdata[port_iso_pkg::TEST_MSB:port_iso_pkg::TEST_LSB];
      power_reg <= bus_wdata[port_iso_pkg::POWER_BIT];
      sleep_reg <= bus_wdata[port_iso_pkg::SLEEP_BIT];
      resume_reg <= bus_wdata[port_iso_pkg::RESUME_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ind_reg <= port_iso_pkg::IND_RST;
      own_reg <= port_iso_pkg::OWN_RST;
      enable_reg <= port_iso_pkg::FLAG_RST;
      present_reg <= port_iso_pkg::FLAG_RST;
      change_reg <= port_iso_pkg::FLAG_RST;
      cf_prev_reg <= port_iso_pkg::FLAG_RST;
      power_out_reg <= port_iso_pkg::FLAG_RST;
    end else begin
      ind_reg <= ind_next;
      own_reg <= own_next;
      enable_reg <= enable_next;
      present_reg <= port_connected;
      change_reg <= change_next;
      cf_prev_reg <= configured_flag;
      power_out_reg <= eff_power;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_reg <= COUNT'(port_iso_pkg::DONE_RST);
      bypass_reg <= COUNT'(port_iso_pkg::BYPASS_RST);
    end else begin
      done_reg <= done_next;
      bypass_reg <= wr_bypass ? COUNT'(bus_wdata) : bypass_reg;
    end
  end

  // The walk restarts at position zero on a start from idle; a stop wins over a step.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      walk_reg <= port_iso_pkg::WALK_IDLE;
      index_reg <= '0;
      process_reg <= 1'b0;
    end else begin
      case (walk_reg)
        port_iso_pkg::WALK_IDLE: begin
          process_reg <= 1'b0;
          if (sched_start) begin
            walk_reg <= port_iso_pkg::WALK_RUN;
            index_reg <= '0;
          end
        end
        port_iso_pkg::WALK_RUN: begin
          if (sched_stop) begin
            walk_reg <= port_iso_pkg::WALK_IDLE;
            process_reg <= 1'b0;
          end else if (sched_step) begin
            process_reg <= scan_bus.process;
            index_reg <= scan_bus.next_index;
          end
        end
        default: begin
          walk_reg <= port_iso_pkg::WALK_IDLE;
        end
      endcase
    end
  end

  assign bus_rdata = rdata_reg;
  assign port_test_select = test_reg;
  assign indicator_control = ind_reg;
  assign companion_ownership = own_reg;
  assign port_power = power_out_reg;
  assign port_enable = enable_reg;
  assign sleep_request = sleep_reg;
  assign resume_drive = resume_reg;
  assign sched_active = (walk_reg == port_iso_pkg::WALK_RUN);
  assign sched_index = index_reg;
  assign sched_process = process_reg;

  // Checks of the register behaviour against its causes.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_cf_rise;
    !configured_flag ##1 configured_flag;
  endsequence

  sequence s_portsc_read;
    bus_rd && (bus_addr == port_iso_pkg::PORTSC_OFF);
  endsequence

  sequence s_bypassed_step;
    walk_advance && !sched_stop && bypass_reg[index_reg];
  endsequence

  property p_own_hold;
    !configured_flag |=> companion_ownership;
  endproperty
  a_own_hold: assert property (p_own_hold) else $error("ownership not held while unconfigured");

  property p_own_clear;
    s_cf_rise |=> !companion_ownership;
  endproperty
  a_own_clear: assert property (p_own_clear) else $error("ownership not cleared on configure");

  property p_test_write;
    wr_portsc |=> port_test_select == $past(bus_wdata[port_iso_pkg::TEST_MSB:port_iso_pkg::TEST_LSB]);
  endproperty
  a_test_write: assert property (p_test_write) else $error("test select not taken");

  property p_ind_locked;
    (wr_portsc && !indicator_capable) |=> $stable(indicator_control);
  endproperty
  a_ind_locked: assert property (p_ind_locked) else $error("indicator written without capability");

  property p_power_fixed;
    !power_switch_capable |=> port_power;
  endproperty
  a_power_fixed: assert property (p_power_fixed) else $error("power not fixed on");

  property p_line_state;
    s_portsc_read |=> bus_rdata[port_iso_pkg::DP_BIT:port_iso_pkg::DM_BIT] == {$past(line_dp), $past(line_dm)};
  endproperty
  a_line_state: assert property (p_line_state) else $error("line state misreported");

  property p_unpowered_read;
    (s_portsc_read and !eff_power) |=> (bus_rdata[15:14] == 2'h0) && (bus_rdata[8:0] == 9'h000);
  endproperty
  a_unpowered_read: assert property (p_unpowered_read) else $error("status visible without power");

  property p_change_set;
    (port_connected != present_reg) |=> change_reg [*2] or (change_reg ##1 $past(wr_portsc));
  endproperty
  a_change_set: assert property (p_change_set) else $error("connect change lost");

  property p_done_keep;
    (desc_done != '0) |=> (done_reg & $past(desc_done)) == $past(desc_done);
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("completion lost");

  property p_done_clear;
    rd_done |=> (done_reg == $past(desc_done)) && (bus_rdata == $past(done_reg));
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("read did not clear map");

  property p_skip;
    s_bypassed_step |=> !sched_process && (sched_index == IW'($past(index_reg) + 1'b1));
  endproperty
  a_skip: assert property (p_skip) else $error("bypassed descriptor processed or link followed");

  property p_reset_read;
    (s_portsc_read and eff_power) |=> bus_rdata[port_iso_pkg::PRST_BIT] == $past(port_in_reset);
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("port reset status misreported");

  property p_sleep_read;
    (s_portsc_read and (eff_power && port_suspended)) |=> bus_rdata[port_iso_pkg::SLEEP_BIT];
  endproperty
  a_sleep_read: assert property (p_sleep_read) else $error("suspend not reported");

  property p_resume_read;
    (s_portsc_read and (eff_power && resume_detected)) |=> bus_rdata[port_iso_pkg::RESUME_BIT];
  endproperty
  a_resume_read: assert property (p_resume_read) else $error("resume not reported");

  property p_detach_disable;
    (present_reg && !port_connected) |=> !port_enable;
  endproperty
  a_detach_disable: assert property (p_detach_disable) else $error("enable kept after detach");

  property p_present_read;
    (s_portsc_read and (eff_power && present_reg)) |=> bus_rdata[port_iso_pkg::PRESENT_BIT];
  endproperty
  a_present_read: assert property (p_present_read) else $error("attached device not reported");

  property p_step_process;
    (walk_advance && !sched_stop && desc_valid && !bypass_reg[index_reg]) |=> sched_process;
  endproperty
  a_step_process: assert property (p_step_process) else $error("valid descriptor not processed");

endmodule // port_status_iso_regs

// ==== sim/iso_desc_model.sv ====
/*
  Far-side model of the isochronous descriptor store: valid flag and next link for each walk position.
  Assumes the register bank reads these fields combinationally at its current walk index.
*/
`timescale 1ns/10ps
module iso_desc_model (
  input wire logic [4:0] sched_index,
  output logic desc_valid,
  output logic desc_link_valid,
  output logic [4:0] desc_link
);
  // Position 1 is the only bypassed one, and no active link points at it.
  // Position 6 holds no valid descriptor, so the walk must pass it unprocessed.
  always_comb begin
    desc_valid = 1'b1;
    desc_link_valid = 1'b1;
    desc_link = 5'h09;
    case (sched_index)
      5'h00: desc_link_valid = 1'b0;
      5'h02: desc_link = 5'h06;
      5'h06: desc_valid = 1'b0;
      default: desc_valid = 1'b1;
    endcase
  end
endmodule // iso_desc_model

// ==== sim/port_status_and_iso_descriptor_maps_tb.sv ====
/*
  Self-checking bench for the port status register and the isochronous descriptor maps.
  Assumes the one-cycle read and write strobes of the register bank and a far-side descriptor model.
*/
`timescale 1ns/10ps
module port_status_and_iso_descriptor_maps_tb;
  logic clock = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [31:0] bus_wdata = 32'h00000000, desc_done = 32'h00000000, bus_rdata, d;
  logic configured_flag = 1'b0, indicator_capable = 1'b0, power_switch_capable = 1'b1;
  logic line_dp = 1'b0, line_dm = 1'b0, port_connected = 1'b0, port_in_reset = 1'b0;
  logic port_suspended = 1'b0, resume_detected = 1'b0;
  logic sched_start = 1'b0, sched_stop = 1'b0, sched_step = 1'b0;
  logic desc_valid, desc_link_valid, companion_ownership, port_power, port_enable;
  logic sleep_request, resume_drive, sched_active, sched_process;
  logic [4:0] desc_link, sched_index;
  logic [3:0] port_test_select;
  logic [1:0] indicator_control;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #25 clock = ~clock;

  port_status_iso_regs port_status_iso_regs_i (.clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .configured_flag(configured_flag), .indicator_capable(indicator_capable),
    .power_switch_capable(power_switch_capable), .line_dp(line_dp), .line_dm(line_dm),
    .port_connected(port_connected), .port_in_reset(port_in_reset), .port_suspended(port_suspended),
    .resume_detected(resume_detected), .desc_done(desc_done), .sched_start(sched_start),
    .sched_stop(sched_stop), .sched_step(sched_step), .desc_valid(desc_valid),
    .desc_link_valid(desc_link_valid), .desc_link(desc_link), .port_test_select(port_test_select),
    .indicator_control(indicator_control), .companion_ownership(companion_ownership),
    .port_power(port_power), .port_enable(port_enable), .sleep_request(sleep_request),
    .resume_drive(resume_drive), .sched_active(sched_active), .sched_index(sched_index),
    .sched_process(sched_process));

  iso_desc_model iso_desc_model_i (.sched_index(sched_index), .desc_valid(desc_valid),
    .desc_link_valid(desc_link_valid), .desc_link(desc_link));

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // The done pulse rides along with the read so that a completion can meet a clearing read.
  task automatic rd(input logic [15:0] a, input logic [31:0] done, output logic [31:0] q);
    @(posedge clock);
    #1;
    bus_addr = a;
    bus_rd = 1'b1;
    desc_done = done;
    @(posedge clock);
    #1;
    bus_rd = 1'b0;
    desc_done = 32'h00000000;
    q = bus_rdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clock);
    #1;
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(posedge clock);
    #1;
    bus_wr = 1'b0;
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bits(input string name, input logic [4:0] exp, input logic [4:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rchk(input string name, input logic [15:0] a, input logic [31:0] exp);
    rd(a, 32'h00000000, d);
    chk_word(name, exp, d);
  endtask

  task automatic sched(input int k);
    @(posedge clock);
    #1;
    sched_start = (k == 0);
    sched_step = (k == 1);
    sched_stop = (k == 2);
    @(posedge clock);
    #1;
    sched_start = 1'b0;
    sched_step = 1'b0;
    sched_stop = 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    test_done;
  end

  initial begin
    tick(12);
    sys_rst = 1'b0;
    rchk("port", port_iso_pkg::PORTSC_OFF, 32'h00002000);
    rchk("bypass", port_iso_pkg::ISO_BYPASS_OFF, 32'hffffffff);
    rchk("done", port_iso_pkg::ISO_DONE_OFF, 32'h00000000);
    chk_bits("owner", 5'h01, 5'(companion_ownership));
    // Status inputs active while unpowered must stay hidden, line state excepted.
    port_connected = 1'b1;
    port_in_reset = 1'b1;
    port_suspended = 1'b1;
    resume_detected = 1'b1;
    line_dp = 1'b1;
    tick(3);
    wr(port_iso_pkg::PORTSC_OFF, 32'h00050000);
    rchk("unpowered", port_iso_pkg::PORTSC_OFF, 32'h00052800);
    chk_bits("test", 5'h05, 5'(port_test_select));
    wr(port_iso_pkg::PORTSC_OFF, 32'h0000d000);
    rchk("powered", port_iso_pkg::PORTSC_OFF, 32'h000039c3);
    chk_bits("ind_locked", 5'h00, 5'(indicator_control));
    indicator_capable = 1'b1;
    wr(port_iso_pkg::PORTSC_OFF, 32'h00009006);
    rchk("enable", port_iso_pkg::PORTSC_OFF, 32'h0000b9c5);
    chk_bits("ind", 5'h02, 5'(indicator_control));
    chk_bits("enable_pin", 5'h01, 5'(port_enable));
    port_in_reset = 1'b0;
    port_suspended = 1'b0;
    resume_detected = 1'b0;
    wr(port_iso_pkg::PORTSC_OFF, 32'h00001084);
    rchk("sleep", port_iso_pkg::PORTSC_OFF, 32'h00003885);
    chk_bits("sleep_pin", 5'h01, 5'(sleep_request));
    wr(port_iso_pkg::PORTSC_OFF, 32'h00001044);
    rchk("resume", port_iso_pkg::PORTSC_OFF, 32'h00003845);
    chk_bits("resume_pin", 5'h01, 5'(resume_drive));
    port_connected = 1'b0;
    tick(3);
    rchk("detach", port_iso_pkg::PORTSC_OFF, 32'h00003842);
    configured_flag = 1'b1;
    tick(2);
    chk_bits("owner_rise", 5'h00, 5'(companion_ownership));
    rchk("owner_rd", port_iso_pkg::PORTSC_OFF, 32'h00001842);
    wr(port_iso_pkg::PORTSC_OFF, 32'h00003000);
    rchk("owner_wr", port_iso_pkg::PORTSC_OFF, 32'h00003802);
    configured_flag = 1'b0;
    tick(2);
    chk_bits("owner_unconf", 5'h01, 5'(companion_ownership));
    configured_flag = 1'b1;
    tick(2);
    chk_bits("owner_again", 5'h00, 5'(companion_ownership));
    for (int i = 0; i < 4; i++) begin
      line_dp = i[1];
      line_dm = i[0];
      tick(2);
      rd(port_iso_pkg::PORTSC_OFF, 32'h00000000, d);
      chk_bits("line", 5'(i), 5'(d[11:10]));
    end
    power_switch_capable = 1'b0;
    wr(port_iso_pkg::PORTSC_OFF, 32'h00000000);
    tick(2);
    chk_bits("power_fixed", 5'h01, 5'(port_power));
    // Completions meet a clearing read; the late one must survive to the next read.
    rd(16'h0068, 32'h00000011, d);
    chk_word("unmapped", 32'h00000000, d);
    rd(port_iso_pkg::ISO_DONE_OFF, 32'h00000100, d);
    chk_word("done_first", 32'h00000011, d);
    rchk("done_late", port_iso_pkg::ISO_DONE_OFF, 32'h00000100);
    rchk("done_clear", port_iso_pkg::ISO_DONE_OFF, 32'h00000000);
    wr(port_iso_pkg::ISO_DONE_OFF, 32'hffffffff);
    rchk("done_ro", port_iso_pkg::ISO_DONE_OFF, 32'h00000000);
    wr(port_iso_pkg::ISO_BYPASS_OFF, 32'h00000002);
    rchk("bypass_wr", port_iso_pkg::ISO_BYPASS_OFF, 32'h00000002);
    sched(0);
    chk_bits("active", 5'h01, 5'(sched_active));
    sched(1);
    chk_bits("idx0", 5'h01, sched_index);
    chk_bits("proc0", 5'h01, 5'(sched_process));
    sched(1);
    chk_bits("idx1", 5'h02, sched_index);
    chk_bits("proc1", 5'h00, 5'(sched_process));
    sched(1);
    chk_bits("idx2", 5'h06, sched_index);
    chk_bits("proc2", 5'h01, 5'(sched_process));
    sched(1);
    chk_bits("idx3", 5'h07, sched_index);
    chk_bits("proc3", 5'h00, 5'(sched_process));
    sched(2);
    chk_bits("stopped", 5'h00, {3'h0, sched_active, sched_process});
    test_done;
  end
endmodule // port_status_and_iso_descriptor_maps_tb
